/* hw/ddc_channel_control.sv */
`timescale 1ns/1ps
// Functional notes
// - soft reset bit holds oscillator in reset
// - sysref resync: off, every event, once
// - mixer select: 0 real, 1 complex
// - gain select: 0 dB or 6 dB
// - if 00 variable, 01 zero if bypass
// - if 10 quarter rate, 11 full-scale test
// - code 11: by 2 with c2r, else 1
// - i and q each pick channel a/b
// - input routing resets to zero, channel a
module ddc_channel_control (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // converter sample streams
  input  wire logic [11:0] first_converter_channel,
  input  wire logic [11:0] second_converter_channel,
  input  wire logic        sample_valid,
  input  wire logic        sysref,
  // downconverted output
  output logic [11:0]      ddc_i,
  output logic [11:0]      ddc_q,
  output logic             ddc_valid
);
  // register map selector
  typedef enum logic [3:0] {
    SEL_NONE  = 4'b0001,
    SEL_SYNC  = 4'b0010,
    SEL_CTRL  = 4'b0100,
    SEL_ROUTE = 4'b1000
  } reg_sel_t;

  // software registers
  logic [7:0] sync_reg, next_sync_reg;       // sync control
  logic [7:0] ctrl_reg, next_ctrl_reg;       // channel control
  logic [7:0] route_reg, next_route_reg;     // input routing
  logic       armed, next_armed;             // one-shot sysref armed
  // active copies used by the datapath
  logic       act_complex, next_act_complex; // mixer type in use
  logic       act_gain, next_act_gain;       // gain in use
  logic       act_c2r, next_act_c2r;         // c2r in use
  logic [1:0] act_if, next_act_if;           // if mode in use
  logic [1:0] act_dec, next_act_dec;         // decimation in use
  // bus answer next values
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  // decode helpers
  reg_sel_t    setup_sel;                    // decode in setup cycle
  reg_sel_t    access_sel;                   // decode in access cycle
  logic        wr_fire;                      // write commits this edge
  logic        setup;                        // setup phase seen
  // datapath
  logic [11:0]        phase;                 // oscillator phase
  logic               dec_idle;              // no half pair pending
  logic               mix_valid, next_mix_valid;
  logic signed [11:0] mix_i, next_mix_i;     // mixer output i
  logic signed [11:0] mix_q, next_mix_q;     // mixer output q
  logic signed [11:0] src_i, src_q;          // routed inputs
  logic [1:0]         quad;                  // phase quadrant
  logic               dec_valid;
  logic signed [11:0] dec_i, dec_q;
  logic [11:0]        next_ddc_i, next_ddc_q;
  logic               next_ddc_valid;
  logic               sync_hit;              // sysref resync taken

  ddc_cfg_if cfg ();

  // word address to register, shared by read and write
  function automatic reg_sel_t decode(input logic [13:0] addr);
    reg_sel_t s;
    s = SEL_NONE;
    if (addr[13:2] == ddc_pkg::IDX_SYNC) begin
      s = SEL_SYNC;
    end else if (addr[13:2] == ddc_pkg::IDX_CTRL) begin
      s = SEL_CTRL;
    end else if (addr[13:2] == ddc_pkg::IDX_ROUTE) begin
      s = SEL_ROUTE;
    end
    return s;
  endfunction

  // multiply by +1, 0 or -1 without a multiplier; the 13-bit result holds negated -full scale
  function automatic logic signed [12:0] weigh(input logic signed [11:0] x,
                                               input logic [1:0] w);
    logic signed [12:0] r;
    r = 13'(x);
    unique case (w)
      2'h0: r = '0;
      2'h1: r = 13'(x);
      2'h2: r = -13'(x);
      2'h3: r = '0;
    endcase
    return r;
  endfunction

  // clamp to the 12-bit signed range
  function automatic logic signed [11:0] clamp(input logic signed [12:0] x);
    logic signed [11:0] r;
    r = x[11:0];
    if (x > 13'sh07ff) begin
      r = 12'sh7ff;
    end else if (x < -13'sh0800) begin
      r = 12'sh800;
    end
    return r;
  endfunction

  // bus decode
  always_comb begin
    setup = psel && !penable;
    setup_sel = decode(paddr);
    access_sel = decode(paddr);
    wr_fire = psel && penable && pready && pwrite && pstrb[0];
  end

  // register file next values
  always_comb begin
    next_sync_reg = sync_reg;
    next_ctrl_reg = ctrl_reg;
    next_route_reg = route_reg;
    next_armed = armed;
    if (wr_fire) begin
      unique case (access_sel)
        SEL_SYNC: next_sync_reg = pwdata[7:0] & ddc_pkg::SYNC_MASK;
        SEL_CTRL: next_ctrl_reg = pwdata[7:0] & ddc_pkg::CTRL_MASK;
        SEL_ROUTE: next_route_reg = pwdata[7:0] & ddc_pkg::ROUTE_MASK;
        SEL_NONE: next_route_reg = route_reg;
      endcase
    end
    // one shot is spent by the event it takes
    if (sync_hit && sync_reg[ddc_pkg::SYNC_MODE_LSB + 1]) begin
      next_armed = 1'b0;
    end
    // writing a one-shot code re-arms; the write wins over the event
    if (wr_fire && access_sel == SEL_SYNC && pwdata[ddc_pkg::SYNC_MODE_LSB + 1]) begin
      next_armed = 1'b1;
    end
  end

  // sysref resync selection
  always_comb begin
    sync_hit = 1'b0;
    if (sysref) begin
      if (sync_reg[ddc_pkg::SYNC_MODE_LSB +: 2] == ddc_pkg::SYNC_EVERY) begin
        sync_hit = 1'b1; // every event
      end else if (sync_reg[ddc_pkg::SYNC_MODE_LSB + 1]) begin
        sync_hit = armed; // first event only
      end
    end
  end

  // read data and answer, computed in the setup cycle
  always_comb begin
    next_prdata = '0;
    next_pready = setup;
    next_pslverr = setup && (setup_sel == SEL_NONE);
    if (setup && !pwrite) begin
      unique case (setup_sel)
        SEL_SYNC: next_prdata = {24'h000000, sync_reg};
        SEL_CTRL: next_prdata = {24'h000000, ctrl_reg};
        SEL_ROUTE: next_prdata = {24'h000000, route_reg};
        SEL_NONE: next_prdata = '0;
      endcase
    end
  end

  // registers and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= ddc_pkg::SYNC_RESET;
      ctrl_reg <= ddc_pkg::CTRL_RESET;
      route_reg <= ddc_pkg::ROUTE_RESET; // channel a on both paths
      armed <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      sync_reg <= next_sync_reg;
      ctrl_reg <= next_ctrl_reg;
      route_reg <= next_route_reg;
      armed <= next_armed;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // adopt new settings only between whole pairs, so no pair mixes two settings
  always_comb begin
    next_act_complex = act_complex;
    next_act_gain = act_gain;
    next_act_c2r = act_c2r;
    next_act_if = act_if;
    next_act_dec = act_dec;
    // taken only while no sample enters, so the mixer, oscillator and decimator
    // all see the new set from the same first sample; a gapless stream keeps the old set
    if (!sample_valid && dec_idle && !mix_valid) begin
      next_act_complex = ctrl_reg[ddc_pkg::CTRL_MIXER_BIT];
      next_act_gain = ctrl_reg[ddc_pkg::CTRL_GAIN_BIT];
      next_act_c2r = ctrl_reg[ddc_pkg::CTRL_C2R_BIT];
      next_act_if = ctrl_reg[ddc_pkg::CTRL_IF_LSB +: 2];
      next_act_dec = ctrl_reg[ddc_pkg::CTRL_DEC_LSB +: 2];
    end
  end

  // active settings registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_complex <= 1'b0;
      act_gain <= 1'b0;
      act_c2r <= 1'b0;
      act_if <= 2'h0;
      act_dec <= 2'h0;
    end else begin
      act_complex <= next_act_complex;
      act_gain <= next_act_gain;
      act_c2r <= next_act_c2r;
      act_if <= next_act_if;
      act_dec <= next_act_dec;
    end
  end

  // settings to the oscillator and decimator
  assign cfg.mixer_complex = act_complex;
  assign cfg.c2r_en = act_c2r;
  assign cfg.if_mode = ddc_pkg::if_mode_t'(act_if);
  assign cfg.dec_code = act_dec;
  assign cfg.nco_hold = sync_reg[ddc_pkg::SYNC_RESET_BIT];
  assign cfg.nco_resync = sync_hit;

  ddc_nco u_nco (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg),
    .advance (sample_valid),
    .phase   (phase)
  );

  // routing and mixing; coarse quadrant oscillator keeps the mixer multiplier-free
  always_comb begin
    // each path picks its own converter channel
    src_i = route_reg[ddc_pkg::ROUTE_I_BIT] ? second_converter_channel
                                            : first_converter_channel;
    src_q = route_reg[ddc_pkg::ROUTE_Q_BIT] ? second_converter_channel
                                            : first_converter_channel;
    if (cfg.if_mode == ddc_pkg::IF_TEST) begin
      src_i = ddc_pkg::PLUS_FULL_SCALE; // inputs forced high
      src_q = ddc_pkg::PLUS_FULL_SCALE;
    end
    quad = phase[11:10];
    next_mix_valid = sample_valid;
    next_mix_i = mix_i;
    next_mix_q = mix_q;
    if (sample_valid) begin
      if (cfg.if_mode == ddc_pkg::IF_ZERO) begin
        next_mix_i = src_i; // mixer bypassed
        next_mix_q = act_complex ? src_q : 12'sh000;
      end else if (act_complex) begin
        // complex mixer variable, quarter and test modes rotate
        next_mix_i = clamp(weigh(src_i, cos_w(quad)) + weigh(src_q, sin_w(quad)));
        next_mix_q = clamp(weigh(src_q, cos_w(quad)) - weigh(src_i, sin_w(quad)));
      end else begin
        // real mixer uses the i path only
        next_mix_i = clamp(weigh(src_i, cos_w(quad)));
        next_mix_q = clamp(-weigh(src_i, sin_w(quad)));
      end
    end
  end

  // cosine weight per quadrant: +1, 0, -1, 0
  function automatic logic [1:0] cos_w(input logic [1:0] q);
    logic [1:0] w;
    w = 2'h0;
    unique case (q)
      2'h0: w = 2'h1;
      2'h1: w = 2'h0;
      2'h2: w = 2'h2;
      2'h3: w = 2'h0;
    endcase
    return w;
  endfunction

  // sine weight per quadrant: 0, +1, 0, -1
  function automatic logic [1:0] sin_w(input logic [1:0] q);
    logic [1:0] w;
    w = 2'h0;
    unique case (q)
      2'h0: w = 2'h0;
      2'h1: w = 2'h1;
      2'h2: w = 2'h0;
      2'h3: w = 2'h2;
    endcase
    return w;
  endfunction

  // mixer stage register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_valid <= 1'b0;
      mix_i <= '0;
      mix_q <= '0;
    end else begin
      mix_valid <= next_mix_valid;
      mix_i <= next_mix_i;
      mix_q <= next_mix_q;
    end
  end

  ddc_decim u_decim (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (cfg),
    .in_valid  (mix_valid),
    .in_i      (mix_i),
    .in_q      (mix_q),
    .out_valid (dec_valid),
    .out_i     (dec_i),
    .out_q     (dec_q),
    .idle      (dec_idle)
  );

  // gain and complex to real at the output
  always_comb begin
    next_ddc_valid = dec_valid;
    next_ddc_i = ddc_i;
    next_ddc_q = ddc_q;
    if (dec_valid) begin
      // 6 dB doubles with saturation, 0 dB passes
      next_ddc_i = act_gain ? clamp({dec_i, 1'b0}) : dec_i;
      next_ddc_q = act_gain ? clamp({dec_q, 1'b0}) : dec_q;
      // real output carries no q part
      if (act_c2r) begin
        next_ddc_q = '0;
      end
    end
  end

  // output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddc_valid <= 1'b0;
      ddc_i <= '0;
      ddc_q <= '0;
    end else begin
      ddc_valid <= next_ddc_valid;
      ddc_i <= next_ddc_i;
      ddc_q <= next_ddc_q;
    end
  end
endmodule // ddc_channel_control

/* common/ddc_pkg.sv */
package ddc_pkg;
  // bus geometry: printed offsets are word indices, byte address is four times that
  localparam int unsigned ADDR_W = 14;
  localparam logic [11:0] IDX_SYNC  = 12'h300;
  localparam logic [11:0] IDX_CTRL  = 12'h310;
  localparam logic [11:0] IDX_ROUTE = 12'h311;
  // field positions
  localparam int unsigned SYNC_MODE_LSB = 0;
  localparam int unsigned SYNC_RESET_BIT = 4;
  localparam int unsigned CTRL_DEC_LSB = 0;
  localparam int unsigned CTRL_C2R_BIT = 3;
  localparam int unsigned CTRL_IF_LSB = 4;
  localparam int unsigned CTRL_GAIN_BIT = 6;
  localparam int unsigned CTRL_MIXER_BIT = 7;
  localparam int unsigned ROUTE_I_BIT = 0;
  localparam int unsigned ROUTE_Q_BIT = 2;
  // writable bits and values after reset
  localparam logic [7:0] SYNC_MASK  = 8'h13;
  localparam logic [7:0] CTRL_MASK  = 8'hfb;
  localparam logic [7:0] ROUTE_MASK = 8'h05;
  localparam logic [7:0] SYNC_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  // datapath
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned NCO_W = 12;
  localparam logic [11:0] NCO_STEP_DEFAULT = 12'h100;
  localparam logic [11:0] QUARTER_STEP = 12'h400;
  localparam logic [11:0] PLUS_FULL_SCALE = 12'h7ff;
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_EVERY = 2'h1;
  localparam logic [1:0] DEC_SPECIAL = 2'h3;
  typedef enum logic [1:0] {
    IF_VARIABLE = 2'h0, IF_ZERO = 2'h1, IF_QUARTER = 2'h2, IF_TEST = 2'h3
  } if_mode_t;
endpackage

/* common/ddc_cfg_if.sv */
`timescale 1ns/1ps
interface ddc_cfg_if;
  logic             mixer_complex; // active mixer type
  logic             c2r_en;        // complex to real enable
  ddc_pkg::if_mode_t if_mode;      // active if mode
  logic [1:0]       dec_code;      // active decimation code
  logic             nco_hold;      // oscillator soft reset
  logic             nco_resync;    // one-cycle resync pulse
  modport src (output mixer_complex, c2r_en, if_mode, dec_code, nco_hold, nco_resync);
  modport sink (input mixer_complex, c2r_en, if_mode, dec_code, nco_hold, nco_resync);
endinterface

/* hw/ddc_nco.sv */
`timescale 1ns/1ps
module ddc_nco (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // settings
  ddc_cfg_if.sink          cfg,
  // sample strobe and phase
  input  wire logic        advance,
  output logic [11:0]      phase
);
  logic [11:0] next_phase; // accumulator next value
  logic [11:0] step;       // phase increment

  // accumulator next value
  always_comb begin
    step = (cfg.if_mode == ddc_pkg::IF_QUARTER) ? ddc_pkg::QUARTER_STEP
                                                : ddc_pkg::NCO_STEP_DEFAULT;
    next_phase = phase;
    if (cfg.nco_hold) begin
      next_phase = '0; // held in reset
    end else if (cfg.if_mode == ddc_pkg::IF_ZERO) begin
      next_phase = '0; // oscillator disabled
    end else if (cfg.nco_resync) begin
      next_phase = '0; // realigned to sysref
    end else if (advance) begin
      next_phase = phase + step;
    end
  end

  // accumulator register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end
endmodule // ddc_nco

/* hw/ddc_decim.sv */
`timescale 1ns/1ps
module ddc_decim (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // settings
  ddc_cfg_if.sink                 cfg,
  // mixed samples in
  input  wire logic               in_valid,
  input  wire logic signed [11:0] in_i,
  input  wire logic signed [11:0] in_q,
  // decimated samples out
  output logic                    out_valid,
  output logic signed [11:0]      out_i,
  output logic signed [11:0]      out_q,
  output logic                    idle
);
  typedef enum logic [1:0] {ST_EVEN = 2'b01, ST_ODD = 2'b10} dec_state_t;
  dec_state_t        state, next_state;         // pair position
  logic signed [11:0] held_i, held_q;           // first of a pair
  logic signed [11:0] next_held_i, next_held_q;
  logic               next_valid;
  logic signed [11:0] next_i, next_q;
  logic               by_two;                   // decimate by 2 selected
  logic signed [12:0] sum_i, sum_q;

  // pairing and averaging
  always_comb begin
    // code 11 halves only with complex to real on
    by_two = (cfg.dec_code == ddc_pkg::DEC_SPECIAL) ? cfg.c2r_en : 1'b1;
    sum_i = 13'(in_i) + 13'(held_i);
    sum_q = 13'(in_q) + 13'(held_q);
    next_state = state;
    next_held_i = held_i;
    next_held_q = held_q;
    next_valid = 1'b0;
    next_i = out_i;
    next_q = out_q;
    if (in_valid) begin
      unique case (state)
        ST_EVEN: begin
          if (by_two) begin
            next_held_i = in_i;
            next_held_q = in_q;
            next_state = ST_ODD;
          end else begin
            next_valid = 1'b1; // pass through
            next_i = in_i;
            next_q = in_q;
          end
        end
        ST_ODD: begin
          next_valid = 1'b1; // average of the pair
          next_i = sum_i[12:1];
          next_q = sum_q[12:1];
          next_state = ST_EVEN;
        end
      endcase
    end
  end

  // pipeline registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_EVEN;
      held_i <= '0;
      held_q <= '0;
      out_valid <= 1'b0;
      out_i <= '0;
      out_q <= '0;
    end else begin
      state <= next_state;
      held_i <= next_held_i;
      held_q <= next_held_q;
      out_valid <= next_valid;
      out_i <= next_i;
      out_q <= next_q;
    end
  end

  assign idle = (state == ST_EVEN);
endmodule // ddc_decim

/* tb/ddc_channel_control_sva.sv */
`timescale 1ns/1ps
module ddc_channel_control_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sample stream
  input wire logic        sample_valid,
  input wire logic [11:0] ddc_i,
  input wire logic [11:0] ddc_q,
  input wire logic        ddc_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unmapped; // word index hits none of the three registers
  assign unmapped = !(paddr[13:2] inside {ddc_pkg::IDX_SYNC, ddc_pkg::IDX_CTRL,
                                          ddc_pkg::IDX_ROUTE});
  // first cycle of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  // access cycle being answered
  sequence access_s;
    psel && penable && pready;
  endsequence
  answer_next_a: assert property (setup_s |=> pready)
    else $error("no answer right after setup");
  pready_pulse_a: assert property (access_s |=> !pready)
    else $error("ready stood longer than one cycle");
  access_only_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  err_decode_a: assert property (setup_s |=> pslverr == $past(unmapped))
    else $error("error flag does not follow address decode");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  valid_cause_a: assert property (ddc_valid |-> $past(sample_valid, 3))
    else $error("output sample without input three cycles before");
  data_hold_a: assert property (!ddc_valid |-> $stable({ddc_i, ddc_q}))
    else $error("output data moved without valid");
endmodule // ddc_channel_control_sva

/* tb/ddc_sample_source.sv */
`timescale 1ns/1ps
// stands in for both converter channels and the link's sysref source
module ddc_sample_source (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // requests from the bench
  input  wire logic        go,
  input  wire logic [11:0] a_val,
  input  wire logic [11:0] b_val,
  input  wire logic        sysref_req,
  // converter side
  output logic [11:0]      first_converter_channel,
  output logic [11:0]      second_converter_channel,
  output logic             sample_valid,
  output logic             sysref
);
  logic [11:0] junk; // moving filler so idle lines never look like the last sample
  // filler flips between 12'h5a3 and its negation 12'ha5d every cycle, a stale sample would be caught
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) junk <= 12'h5a3;
    else junk <= ~junk + 12'h001;
  end
  // data only means something while valid is high
  assign first_converter_channel  = go ? a_val : junk;
  assign second_converter_channel = go ? b_val : ~junk;
  assign sample_valid             = go;
  assign sysref                   = sysref_req; // bench keeps it to one cycle
endmodule // ddc_sample_source

/* tb/ddc_channel_control_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module ddc_channel_control_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        go = 0, sysref_req = 0; // partner requests
  logic [11:0] a_val = 12'h0, b_val = 12'h0, a, b;
  wire  [31:0] prdata;
  wire         pready, pslverr, sample_valid, sysref, ddc_valid;
  wire  [11:0] first_converter_channel, second_converter_channel, ddc_i, ddc_q;
  int          miscompares = 0, comparisons = 0, cycles = 0;
  integer      seed = 32'hd484;
  logic [31:0] rd_d;
  logic        err_d;
  logic [23:0] exp_q[$], e_now, cur, prev; // expected {i, q}
  logic [11:0] idx [3] = '{ddc_pkg::IDX_SYNC, ddc_pkg::IDX_CTRL, ddc_pkg::IDX_ROUTE};
  logic [7:0]  msk [3] = '{ddc_pkg::SYNC_MASK, ddc_pkg::CTRL_MASK, ddc_pkg::ROUTE_MASK};
  logic [7:0]  ctrls [7] = '{8'h13, 8'h53, 8'h93, 8'hd3, 8'h10, 8'h1b, 8'h90};
  logic [7:0]  routes [4] = '{8'h00, 8'h01, 8'h04, 8'h05};

  always #20 pclk = ~pclk;

  ddc_channel_control i_ddc_channel_control (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .first_converter_channel,
    .second_converter_channel, .sample_valid, .sysref, .ddc_i, .ddc_q, .ddc_valid);
  ddc_sample_source i_ddc_sample_source (.pclk, .presetn, .go, .a_val, .b_val,
    .sysref_req, .first_converter_channel, .second_converter_channel, .sample_valid,
    .sysref);

  // verdict in one place; hang guard and output compare share the clock
  task conclude();
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      conclude();
    end
    if (ddc_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(ddc_valid, 1'b0)
      else begin
        e_now = exp_q.pop_front();
        `CHK({ddc_i, ddc_q}, e_now)
      end
    end
  end

  // one apb transfer, held until ready is seen at an edge
  task apb(input logic wr, input logic [11:0] ix, input logic [7:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_d = prdata;
    err_d = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] ix, input logic [7:0] wd);
    apb(1'b1, ix, wd, 4'h1);
  endtask
  task chk_rd(input logic [11:0] ix, input logic [7:0] ev, input logic ee);
    apb(1'b0, ix, 8'h00, 4'h0);
    `CHK(rd_d, {24'h0, ev})
    `CHK(err_d, ee)
  endtask

  // gain stage: doubling with saturation
  function automatic logic [11:0] dbl(input logic [11:0] x, input logic g);
    if (!g) return x;
    if (x[11] != x[10]) return x[11] ? 12'h800 : 12'h7ff;
    return {x[10:0], 1'b0};
  endfunction
  // zero-if bypass: routing picks sources, real or c2r drops q
  function automatic logic [23:0] byp(input logic [11:0] a, b, input logic [7:0] c, r);
    logic [11:0] i, q;
    i = r[0] ? b : a;
    q = r[2] ? b : a;
    if (!c[7] || c[3]) q = 12'h000;
    return {dbl(i, c[6]), dbl(q, c[6])};
  endfunction
  function automatic logic [11:0] avg(input logic [11:0] x, y);
    logic [12:0] s;
    s = {x[11], x} + {y[11], y};
    return s[12:1];
  endfunction
  // coarse oscillator quadrant applied by the real mixer
  function automatic logic [23:0] rot(input logic [11:0] x, input int qd);
    case (qd)
      0: return {x, 12'h000};
      1: return {12'h000, -x};
      2: return {-x, 12'h000};
      default: return {12'h000, x};
    endcase
  endfunction

  task send(input logic [11:0] sa, input logic [11:0] sb);
    @(posedge pclk);
    go <= 1;
    a_val <= sa;
    b_val <= sb;
  endtask
  // stop the stream and let the pipeline empty; every expected sample must be out
  task settle();
    @(posedge pclk);
    go <= 0;
    repeat (8) @(posedge pclk);
    `CHK(exp_q.size(), 0)
  endtask
  task pulse();
    @(posedge pclk);
    sysref_req <= 1;
    @(posedge pclk);
    sysref_req <= 0;
    repeat (2) @(posedge pclk);
  endtask
  // n samples, quadrant of sample k is ((k0 + k) >> sh) mod 4
  task osc_run(input int n, input int k0, input int sh, input logic tst);
    for (int k = 0; k < n; k++) begin
      a = tst ? ddc_pkg::PLUS_FULL_SCALE : {2'b00, 10'($random(seed))};
      exp_q.push_back(rot(a, ((k0 + k) >> sh) & 3));
      send(a, 12'h000);
    end
    settle();
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    // reset values, ignored strobe, writable masks, unmapped word
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, idx[j], 8'hff, 4'h0);
      chk_rd(idx[j], 8'h00, 1'b0);
      wr(idx[j], 8'hff);
      chk_rd(idx[j], msk[j], 1'b0);
      wr(idx[j], 8'h00);
    end
    chk_rd(12'h312, 8'h00, 1'b1);
    // both mixers, both gains, by-1 and by-2 decimation and every routing in zero-if, corners first
    foreach (ctrls[m]) foreach (routes[n]) begin
      wr(ddc_pkg::IDX_ROUTE, routes[n]);
      wr(ddc_pkg::IDX_CTRL, ctrls[m]);
      for (int k = 0; k < 4; k++) begin
        a = (k == 0) ? 12'h7ff : 12'($random(seed));
        b = (k == 0) ? 12'h800 : 12'($random(seed));
        cur = byp(a, b, ctrls[m], routes[n]);
        if (ctrls[m][1:0] == 2'h3 && !ctrls[m][3]) exp_q.push_back(cur);
        else if (k[0]) exp_q.push_back({avg(prev[23:12], cur[23:12]),
                                        avg(prev[11:0], cur[11:0])});
        prev = cur;
        send(a, b);
      end
      settle();
    end
    // test mode under soft reset, then running, then sysref in each sync mode
    wr(ddc_pkg::IDX_ROUTE, 8'h00);
    wr(ddc_pkg::IDX_SYNC, 8'h10);
    wr(ddc_pkg::IDX_CTRL, 8'h33);
    osc_run(8, 0, 31, 1'b1);
    wr(ddc_pkg::IDX_SYNC, 8'h00);
    osc_run(8, 0, 2, 1'b1);
    pulse();
    osc_run(4, 8, 2, 1'b1);
    wr(ddc_pkg::IDX_SYNC, 8'h01);
    pulse();
    osc_run(4, 0, 2, 1'b1);
    wr(ddc_pkg::IDX_SYNC, 8'h02);
    pulse();
    osc_run(2, 0, 2, 1'b1);
    pulse();
    osc_run(4, 2, 2, 1'b1);
    // quarter-rate and variable if with real data from phase zero
    wr(ddc_pkg::IDX_SYNC, 8'h10);
    wr(ddc_pkg::IDX_CTRL, 8'h23);
    wr(ddc_pkg::IDX_SYNC, 8'h00);
    osc_run(8, 0, 0, 1'b0);
    wr(ddc_pkg::IDX_SYNC, 8'h10);
    wr(ddc_pkg::IDX_CTRL, 8'h03);
    wr(ddc_pkg::IDX_SYNC, 8'h00);
    osc_run(8, 0, 2, 1'b0);
    conclude();
  end
endmodule // ddc_channel_control_tb

bind ddc_channel_control ddc_channel_control_sva i_ddc_channel_control_sva (.pclk, .presetn,
  .psel, .penable, .paddr, .prdata, .pready, .pslverr, .sample_valid, .ddc_i, .ddc_q,
  .ddc_valid);
